// >>> design/shb_consts.svh
`ifndef SHB_CONSTS_SVH
`define SHB_CONSTS_SVH
// How it works
// - Serial link: 38400 baud, 8 bits, no parity
// - Accept record types 0, 4, 1 only
// - Drop record data inside the protected region
// - Loader itself lives from address 0x0000
// - No strap: jump to application at 0x0400
// - Strap pin low at power-up selects load
// - Load mode: LED on, then send colon
// - Erase application flash before taking records
// - Blink LED while records arrive and program
// - End: LED steady on if good, else off
// - End: send character 1 or 0
// - Checksum error marks the load failed
// - Strap released: start loaded application

// Clock and link timing
`define SHB_CLK_HZ      125000000
`define SHB_BAUD        38400
`define SHB_BAUD_CYC    (`SHB_CLK_HZ / `SHB_BAUD)
`define SHB_BLINK_MS    100
`define SHB_SETTLE      4'h8

// Record types
`define SHB_REC_DATA    8'h00
`define SHB_REC_EOF     8'h01
`define SHB_REC_EXT     8'h04

// Address map
`define SHB_LOADER_BASE 20'h00000
`define SHB_PROT_END    20'h00400
`define SHB_APP_ENTRY   20'h00400

// Characters
`define SHB_CH_COLON    8'h3a
`define SHB_CH_ONE      8'h31
`define SHB_CH_ZERO     8'h30
`define SHB_CH_XON      8'h11
`define SHB_CH_XOFF     8'h13
`endif

// >>> design/shb_pkg.sv
package shb_pkg;
   // Loader sequence, Gray coded in listed order
   typedef enum logic [3:0] {
      SHB_SAMPLE = 4'h0,
      SHB_ERASE  = 4'h1,
      SHB_PROMPT = 4'h3,
      SHB_RECV   = 4'h2,
      SHB_PROG   = 4'h6,
      SHB_FINISH = 4'h7,
      SHB_REPORT = 4'h5,
      SHB_HALT   = 4'h4,
      SHB_APP    = 4'hc
   } shb_state_t;

   // One flash byte write
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  data;
   } shb_flash_cmd_t;
endpackage : shb_pkg

// >>> design/shb_uart.sv
`timescale 1ns/1ps
`include "shb_consts.svh"
module shb_uart #(
   parameter logic [11:0] BAUD_CYC = 12'(`SHB_BAUD_CYC)
) (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Serial pins
   input  wire logic       rxPin,
   output logic            txPin,
   // Received bytes
   output logic [7:0]      rxData,
   output logic            rxValid,
   // Bytes to send
   input  wire logic [7:0] txData,
   input  wire logic       txValid,
   output logic            txReady
);
   // Bit time in clocks; shorter values only shrink simulation runs
   localparam logic [11:0] BAUD = BAUD_CYC - 12'h001;
   localparam logic [11:0] HALF = BAUD_CYC >> 1;

   logic [2:0]  rxSync_r;
   logic        rxLvl_r;
   logic        rxBusy_r;
   logic [11:0] rxCnt_r;
   logic [3:0]  rxBit_r;
   logic [7:0]  rxSh_r;
   logic        txBusy_r;
   logic [11:0] txCnt_r;
   logic [3:0]  txBit_r;
   logic [9:0]  txSh_r;

   // Three-stage pin sync, level taken when stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rxSync_r <= 3'h7;
         rxLvl_r  <= 1'b1;
      end else begin
         rxSync_r <= {rxSync_r[1:0], rxPin};
         if (rxSync_r[1] == rxSync_r[2])
            rxLvl_r <= rxSync_r[2];
      end
   end

   // Receiver, samples mid-bit, 8N1
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rxBusy_r <= 1'b0;
         rxCnt_r  <= 12'h000;
         rxBit_r  <= 4'h0;
         rxSh_r   <= 8'h00;
         rxData   <= 8'h00;
         rxValid  <= 1'b0;
      end else begin
         rxValid <= 1'b0;
         if (!rxBusy_r) begin
            if (!rxLvl_r) begin
               rxBusy_r <= 1'b1;
               rxCnt_r  <= HALF;
               rxBit_r  <= 4'h0;
            end
         end else if (rxCnt_r != 12'h000) begin
            rxCnt_r <= rxCnt_r - 12'h001;
         end else begin
            rxCnt_r <= BAUD;
            rxBit_r <= rxBit_r + 4'h1;
            if (rxBit_r == 4'h0 && rxLvl_r)
               rxBusy_r <= 1'b0;          // False start
            else if (rxBit_r == 4'h9) begin
               rxBusy_r <= 1'b0;
               rxValid  <= rxLvl_r;
               rxData   <= rxSh_r;
            end else if (rxBit_r != 4'h0)
               rxSh_r <= {rxLvl_r, rxSh_r[7:1]};
         end
      end
   end

   // Transmitter, start bit, 8 data, stop bit
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         txBusy_r <= 1'b0;
         txCnt_r  <= 12'h000;
         txBit_r  <= 4'h0;
         txSh_r   <= 10'h3ff;
      end else if (!txBusy_r) begin
         if (txValid) begin
            txBusy_r <= 1'b1;
            txSh_r   <= {1'b1, txData, 1'b0};
            txCnt_r  <= BAUD;
            txBit_r  <= 4'h0;
         end
      end else if (txCnt_r != 12'h000) begin
         txCnt_r <= txCnt_r - 12'h001;
      end else begin
         txCnt_r <= BAUD;
         txSh_r  <= {1'b1, txSh_r[9:1]};
         txBit_r <= txBit_r + 4'h1;
         if (txBit_r == 4'h9)
            txBusy_r <= 1'b0;
      end
   end

   assign txPin   = txSh_r[0];
   assign txReady = !txBusy_r;

   property p_txStart;
      @(posedge ref_clk) disable iff (!rst_n)
         $rose(txBusy_r) |-> !txPin [*8];
   endproperty
   a_txStart: assert property (p_txStart)
      else $error("start bit not driven low");

   property p_txIdle;
      @(posedge ref_clk) disable iff (!rst_n)
         !txBusy_r |-> txPin;
   endproperty
   a_txIdle: assert property (p_txIdle)
      else $error("idle line not high");
endmodule : shb_uart

// >>> design/shb_loader.sv
`timescale 1ns/1ps
`include "shb_consts.svh"
module shb_loader #(
   parameter logic [23:0] BLINK_HALF =
      24'(`SHB_BLINK_MS * (`SHB_CLK_HZ / 1000)),
   parameter logic [11:0] BAUD_CYC   = 12'(`SHB_BAUD_CYC)
) (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   // Strap and indicator pins
   input  wire logic                   bootSelectPin,
   output logic                        loadStatusLedPin,
   // Serial pins
   input  wire logic                   serRxPin,
   output logic                        serTxPin,
   // Flash port
   output logic                        flashEraseReq,
   output logic                        flashWrReq,
   output shb_pkg::shb_flash_cmd_t     flashCmd,
   input  wire logic                   flashAck,
   // Application start
   output logic                        appStart,
   output logic [19:0]                 appEntry
);
   import shb_pkg::*;

   shb_state_t  state_r;
   logic [2:0]  bootSync_r;
   logic        bootLvl_r;
   logic [3:0]  settle_r;
   logic [7:0]  rxData;
   logic        rxValid;
   logic        txReady;
   logic        txReq_r;
   logic [7:0]  txByte_r;
   logic        err_r;
   logic        ledOn_r;
   logic        gotRec_r;
   logic        blink_r;
   logic [23:0] blinkCnt_r;
   logic        inRec_r;
   logic        nibHalf_r;
   logic [3:0]  hiNib_r;
   logic [8:0]  byteIdx_r;
   logic [7:0]  sum_r;
   logic [7:0]  recLen_r;
   logic [15:0] recAddr_r;
   logic [7:0]  recType_r;
   logic [7:0]  recBuf_r [0:255];
   logic [3:0]  extHi_r;
   logic [7:0]  progIdx_r;
   logic [4:0]  nib;
   logic [7:0]  byteVal;
   logic        byteStrobe;
   logic        recDone;
   logic        sumOk;
   logic [19:0] progAddr;

   // Hex character to {valid, nibble}
   function automatic logic [4:0] hexNib(input logic [7:0] c);
      hexNib = 5'h00;
      if (c >= 8'h30 && c <= 8'h39)
         hexNib = {1'b1, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
         hexNib = {1'b1, c[3:0] + 4'h9};
   endfunction : hexNib

   shb_uart #(.BAUD_CYC(BAUD_CYC)) u_uart (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .rxPin   (serRxPin),
      .txPin   (serTxPin),
      .rxData  (rxData),
      .rxValid (rxValid),
      .txData  (txByte_r),
      .txValid (txReq_r),
      .txReady (txReady)
   );

   // Strap pin sync, three stages, level when two and three agree
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bootSync_r <= 3'h7;
         bootLvl_r  <= 1'b1;
      end else begin
         bootSync_r <= {bootSync_r[1:0], bootSelectPin};
         if (bootSync_r[1] == bootSync_r[2])
            bootLvl_r <= bootSync_r[2];
      end
   end

   // Record byte assembly
   assign nib        = hexNib(rxData);
   assign byteVal    = {hiNib_r, nib[3:0]};
   assign byteStrobe = rxValid && inRec_r && nibHalf_r && nib[4]
                       && state_r == SHB_RECV;
   assign recDone    = byteStrobe && byteIdx_r == ({1'b0, recLen_r} + 9'h004)
                       && byteIdx_r >= 9'h004;
   assign sumOk      = (sum_r + byteVal) == 8'h00;
   assign progAddr   = {extHi_r, recAddr_r + {8'h00, progIdx_r}};

   // Record parser
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         inRec_r   <= 1'b0;
         nibHalf_r <= 1'b0;
         hiNib_r   <= 4'h0;
         byteIdx_r <= 9'h000;
         sum_r     <= 8'h00;
         recLen_r  <= 8'h00;
         recAddr_r <= 16'h0000;
         recType_r <= 8'h00;
      end else if (rxValid && state_r == SHB_RECV) begin
         if (rxData == `SHB_CH_COLON) begin
            inRec_r   <= 1'b1;
            nibHalf_r <= 1'b0;
            byteIdx_r <= 9'h000;
            sum_r     <= 8'h00;
         end else if (inRec_r && !nib[4]) begin
            inRec_r <= 1'b0;
         end else if (inRec_r && !nibHalf_r) begin
            hiNib_r   <= nib[3:0];
            nibHalf_r <= 1'b1;
         end else if (byteStrobe) begin
            nibHalf_r <= 1'b0;
            sum_r     <= sum_r + byteVal;
            byteIdx_r <= byteIdx_r + 9'h001;
            if (recDone)
               inRec_r <= 1'b0;
            case (byteIdx_r)
               9'h000: recLen_r <= byteVal;
               9'h001: recAddr_r[15:8] <= byteVal;
               9'h002: recAddr_r[7:0] <= byteVal;
               9'h003: recType_r <= byteVal;
               default: ;
            endcase
         end
      end
   end

   // Data byte store until the checksum clears the record
   always_ff @(posedge ref_clk) begin
      if (byteStrobe && byteIdx_r >= 9'h004 && !recDone)
         recBuf_r[8'(byteIdx_r - 9'h004)] <= byteVal;
   end

   // Load sequence
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r       <= SHB_SAMPLE;
         settle_r      <= 4'h0;
         err_r         <= 1'b0;
         ledOn_r       <= 1'b0;
         gotRec_r      <= 1'b0;
         extHi_r       <= 4'h0;
         progIdx_r     <= 8'h00;
         txReq_r       <= 1'b0;
         txByte_r      <= 8'h00;
         flashEraseReq <= 1'b0;
         flashWrReq    <= 1'b0;
         flashCmd      <= '0;
         appStart      <= 1'b0;
      end else begin
         if (txReq_r && txReady)
            txReq_r <= 1'b0;
         case (state_r)
            SHB_SAMPLE: begin
               if (settle_r != `SHB_SETTLE)
                  settle_r <= settle_r + 4'h1;
               else if (!bootLvl_r) begin
                  ledOn_r       <= 1'b1;
                  flashEraseReq <= 1'b1;
                  state_r       <= SHB_ERASE;
               end else
                  state_r <= SHB_APP;
            end
            SHB_ERASE: begin
               if (flashAck) begin
                  flashEraseReq <= 1'b0;
                  txReq_r       <= 1'b1;
                  txByte_r      <= `SHB_CH_COLON;
                  state_r       <= SHB_PROMPT;
               end
            end
            SHB_PROMPT: begin
               if (!txReq_r && txReady)
                  state_r <= SHB_RECV;
            end
            SHB_RECV: begin
               if (rxValid && rxData == `SHB_CH_COLON)
                  gotRec_r <= 1'b1;
               if (rxValid && inRec_r && !nib[4]
                   && rxData != `SHB_CH_COLON)
                  err_r <= 1'b1;
               if (recDone && !sumOk)
                  err_r <= 1'b1;
               else if (recDone) begin
                  case (recType_r)
                     `SHB_REC_DATA: begin
                        progIdx_r <= 8'h00;
                        txReq_r   <= 1'b1;
                        txByte_r  <= `SHB_CH_XOFF;
                        state_r   <= SHB_PROG;
                     end
                     `SHB_REC_EXT: extHi_r <= recBuf_r[1][3:0];
                     `SHB_REC_EOF: state_r <= SHB_FINISH;
                     default: err_r <= 1'b1;
                  endcase
               end
            end
            SHB_PROG: begin
               if (flashWrReq) begin
                  if (flashAck) begin
                     flashWrReq <= 1'b0;
                     progIdx_r  <= progIdx_r + 8'h01;
                  end
               end else if (progIdx_r == recLen_r) begin
                  txReq_r  <= 1'b1;
                  txByte_r <= `SHB_CH_XON;
                  state_r  <= SHB_RECV;
               end else if (progAddr < `SHB_PROT_END)
                  progIdx_r <= progIdx_r + 8'h01;
               else begin
                  flashWrReq <= 1'b1;
                  flashCmd   <= '{progAddr, recBuf_r[progIdx_r]};
               end
            end
            SHB_FINISH: begin
               if (!txReq_r && txReady) begin
                  ledOn_r  <= !err_r;
                  txReq_r  <= 1'b1;
                  txByte_r <= err_r ? `SHB_CH_ZERO : `SHB_CH_ONE;
                  state_r  <= SHB_REPORT;
               end
            end
            SHB_REPORT: begin
               if (!txReq_r && txReady)
                  state_r <= SHB_HALT;
            end
            SHB_HALT: begin
               if (bootLvl_r)
                  state_r <= SHB_APP;
            end
            SHB_APP: appStart <= 1'b1;
            default: state_r <= SHB_SAMPLE;
         endcase
      end
   end

   // LED blink while loading, steady result afterwards
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blinkCnt_r       <= 24'h000000;
         blink_r          <= 1'b0;
         loadStatusLedPin <= 1'b0;
      end else begin
         if (blinkCnt_r == BLINK_HALF - 24'h000001) begin
            blinkCnt_r <= 24'h000000;
            blink_r    <= !blink_r;
         end else
            blinkCnt_r <= blinkCnt_r + 24'h000001;
         if (gotRec_r && (state_r == SHB_RECV || state_r == SHB_PROG))
            loadStatusLedPin <= blink_r;
         else
            loadStatusLedPin <= ledOn_r;
      end
   end

   assign appEntry = `SHB_APP_ENTRY;

   property p_protect;
      @(posedge ref_clk) disable iff (!rst_n)
         flashWrReq |-> flashCmd.addr >= `SHB_PROT_END;
   endproperty
   a_protect: assert property (p_protect)
      else $error("write into loader region");

   property p_strapLoad;
      @(posedge ref_clk) disable iff (!rst_n)
         state_r == SHB_SAMPLE && settle_r == `SHB_SETTLE && !bootLvl_r
         |=> state_r == SHB_ERASE && flashEraseReq;
   endproperty
   a_strapLoad: assert property (p_strapLoad)
      else $error("strap low did not start erase");

   property p_eraseFirst;
      @(posedge ref_clk) disable iff (!rst_n)
         $rose(state_r == SHB_PROMPT) |-> $past(state_r) == SHB_ERASE
         && txReq_r && txByte_r == `SHB_CH_COLON;
   endproperty
   a_eraseFirst: assert property (p_eraseFirst)
      else $error("prompt without erase");

   property p_ledBeforeColon;
      @(posedge ref_clk) disable iff (!rst_n)
         state_r == SHB_PROMPT |-> loadStatusLedPin;
   endproperty
   a_ledBeforeColon: assert property (p_ledBeforeColon)
      else $error("LED off while prompting");

   property p_badSum;
      @(posedge ref_clk) disable iff (!rst_n)
         recDone && !sumOk |=> err_r && state_r == SHB_RECV;
   endproperty
   a_badSum: assert property (p_badSum)
      else $error("checksum error not flagged");

   property p_result;
      @(posedge ref_clk) disable iff (!rst_n)
         state_r == SHB_FINISH && !txReq_r && txReady
         |=> txReq_r && txByte_r == (err_r ? `SHB_CH_ZERO : `SHB_CH_ONE)
         ##1 loadStatusLedPin == !err_r;
   endproperty
   a_result: assert property (p_result)
      else $error("wrong result character or LED");

   property p_appStart;
      @(posedge ref_clk) disable iff (!rst_n)
         state_r == SHB_HALT && bootLvl_r |=> ##1 appStart;
   endproperty
   a_appStart: assert property (p_appStart)
      else $error("application not started");

   property p_noStrapApp;
      @(posedge ref_clk) disable iff (!rst_n)
         state_r == SHB_SAMPLE && settle_r == `SHB_SETTLE && bootLvl_r
         |=> ##1 appStart && appEntry == `SHB_APP_ENTRY;
   endproperty
   a_noStrapApp: assert property (p_noStrapApp)
      else $error("no jump to application entry");
endmodule : shb_loader

// >>> dv/shb_host_model.sv
`timescale 1ns/1ps
`include "shb_consts.svh"
// Host terminal: sends record text, honours flow control, collects replies
module shb_host_model #(
   parameter int BitCyc = `SHB_BAUD_CYC
) (
   // Clock
   input  wire logic ref_clk,
   // Serial pins, seen from the host
   output logic      hostTx,
   input  wire logic hostRx
);
   logic [7:0] rxQ[$];
   logic [7:0] rxByte;
   logic       paused;
   logic       frameBad;

   // Line idles high, nothing pending
   initial begin
      hostTx   = 1'b1;
      paused   = 1'b0;
      frameBad = 1'b0;
   end

   // Forget replies and flow state between runs
   task automatic clear;
      rxQ.delete();
      paused   = 1'b0;
      frameBad = 1'b0;
   endtask : clear

   // Start bit, 8 data bits LSB first, stop bit, no parity
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge ref_clk);
         #1;
         hostTx = frame[i];
         repeat (BitCyc - 1) @(posedge ref_clk);
      end
   endtask : send_byte

   // Sends one record, then a line gap so a pending XOFF is seen
   task automatic send_rec(input string s);
      for (int i = 0; i < s.len(); i++) begin
         while (paused) @(posedge ref_clk);
         send_byte(s[i]);
      end
      repeat (12 * BitCyc) @(posedge ref_clk);
      while (paused) @(posedge ref_clk);
   endtask : send_rec

   // Mid-bit sampling of the device's transmit line
   initial forever begin
      @(negedge hostRx);
      repeat (BitCyc / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BitCyc) @(posedge ref_clk);
         rxByte[i] = hostRx;
      end
      repeat (BitCyc) @(posedge ref_clk);
      if (hostRx !== 1'b1) frameBad = 1'b1;
      if (rxByte == `SHB_CH_XOFF) paused = 1'b1;
      else if (rxByte == `SHB_CH_XON) paused = 1'b0;
      else rxQ.push_back(rxByte);
   end
endmodule : shb_host_model

// >>> dv/shb_loader_tb.sv
`timescale 1ns/1ps
`include "shb_consts.svh"
module shb_loader_tb;
   import shb_pkg::*;

   // Shortened bit time keeps the whole run inside the cycle budget
   localparam int BitCyc = 32;

   logic           ref_clk;
   logic           rst_n;
   logic           bootSelectPin;
   logic           loadStatusLedPin;
   logic           serRxPin;
   logic           serTxPin;
   logic           flashEraseReq;
   logic           flashWrReq;
   shb_flash_cmd_t flashCmd;
   logic           flashAck;
   logic           appStart;
   logic [19:0]    appEntry;
   shb_flash_cmd_t wrQ[$];
   int             fails = 0;
   int             checked = 0;
   int             eraseCnt = 0;
   int             ackLat = 3;
   int             waitCnt = 0;
   int             toggles = 0;
   logic           ledPrev = 1'b0;
   logic [7:0]     b;
   int             n;

   shb_loader #(.BLINK_HALF(24'h10), .BAUD_CYC(12'h020)) dut_u (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .bootSelectPin    (bootSelectPin),
      .loadStatusLedPin (loadStatusLedPin),
      .serRxPin         (serRxPin),
      .serTxPin         (serTxPin),
      .flashEraseReq    (flashEraseReq),
      .flashWrReq       (flashWrReq),
      .flashCmd         (flashCmd),
      .flashAck         (flashAck),
      .appStart         (appStart),
      .appEntry         (appEntry)
   );

   shb_host_model #(.BitCyc(BitCyc)) host_u (
      .ref_clk (ref_clk),
      .hostTx  (serRxPin),
      .hostRx  (serTxPin)
   );

   // Clock and time-zero inputs
   initial begin
      ref_clk       = 1'b0;
      rst_n         = 1'b0;
      bootSelectPin = 1'b1;
      flashAck      = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Flash answers each request after ackLat cycles and logs writes
   always @(posedge ref_clk) begin
      #1;
      if (flashAck) flashAck = 1'b0;
      else if (flashEraseReq || flashWrReq) begin
         waitCnt++;
         if (waitCnt >= ackLat) begin
            flashAck = 1'b1;
            waitCnt  = 0;
            if (flashWrReq) wrQ.push_back(flashCmd);
            else eraseCnt++;
         end
      end
   end

   // Counts LED changes to judge blinking
   always @(posedge ref_clk) begin
      if (rst_n && ledPrev !== loadStatusLedPin) toggles++;
      ledPrev = loadStatusLedPin;
   end

   task automatic check(input logic [27:0] seen, input logic [27:0] exp,
                        input string msg);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check

   task automatic summarize;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   // Reset for 10 cycles with the strap at the given level
   task automatic do_reset(input logic strap);
      @(posedge ref_clk);
      #1;
      rst_n         = 1'b0;
      bootSelectPin = strap;
      host_u.clear();
      wrQ.delete();
      eraseCnt = 0;
      repeat (10) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
   endtask : do_reset

   // Waits a bounded time for the next reply character
   task automatic wait_rx(output logic [7:0] c);
      int k;
      k = 0;
      while (host_u.rxQ.size() == 0 && k < 40 * BitCyc) begin
         @(posedge ref_clk);
         k++;
      end
      c = 8'hxx;
      if (host_u.rxQ.size() != 0) c = host_u.rxQ.pop_front();
   endtask : wait_rx

   // Strap high: straight to the application, no load activity
   task automatic t_app_boot;
      do_reset(1'b1);
      for (n = 0; n < 40 && appStart !== 1'b1; n++) @(posedge ref_clk);
      #1;
      check(28'(appStart), 28'h1, "application not started");
      check(28'(appEntry), 28'h00400, "wrong entry address");
      check(28'(eraseCnt), 28'h0, "erase without strap");
      check(28'(loadStatusLedPin), 28'h0, "LED lit in run mode");
      $display("test app_boot done");
   endtask : t_app_boot

   // Strap low: erase, prompt, one record across the protected edge
   task automatic t_load_good;
      int low;
      low    = 0;
      ackLat = 50;
      do_reset(1'b0);
      for (n = 0; n < 40 && flashEraseReq !== 1'b1; n++) @(posedge ref_clk);
      #1;
      check(28'(flashEraseReq), 28'h1, "no erase in load mode");
      repeat (3) @(posedge ref_clk);
      #1;
      check(28'(loadStatusLedPin), 28'h1, "LED not on at entry");
      check(28'(appStart), 28'h0, "application started");
      for (n = 0; n < 40; n++) begin
         @(posedge ref_clk);
         if (serTxPin !== 1'b1) low++;
      end
      check(28'(low), 28'h0, "sent before erase done");
      wait_rx(b);
      check(28'(b), 28'(`SHB_CH_COLON), "no prompt");
      check(28'(eraseCnt), 28'h1, "erase count");
      ackLat  = 3;
      toggles = 0;
      host_u.send_rec(":0203FF00AABB97");
      check(28'(toggles > 2), 28'h1, "LED not blinking");
      check(28'(wrQ.size()), 28'h1, "write count");
      check(wrQ[0], {20'h00400, 8'hbb}, "write content");
      host_u.send_rec(":00000001FF");
      wait_rx(b);
      check(28'(b), 28'(`SHB_CH_ONE), "no success char");
      toggles = 0;
      repeat (100) @(posedge ref_clk);
      #1;
      check(28'(toggles), 28'h0, "LED still blinking");
      check(28'(loadStatusLedPin), 28'h1, "LED not steady on");
      check(28'(appStart), 28'h0, "started with strap low");
      bootSelectPin = 1'b1;
      for (n = 0; n < 20 && appStart !== 1'b1; n++) @(posedge ref_clk);
      #1;
      check(28'(appStart), 28'h1, "no start on strap release");
      check(28'(host_u.frameBad), 28'h0, "bad serial frame");
      $display("test load_good done");
   endtask : t_load_good

   // Extended address, bad checksum and bad type end in failure
   task automatic t_load_err;
      ackLat = 3;
      do_reset(1'b0);
      wait_rx(b);
      check(28'(b), 28'(`SHB_CH_COLON), "no prompt");
      host_u.send_rec(":020000040001F9");
      host_u.send_rec(":01001000CC23");
      host_u.send_rec(":01002000DD00");
      host_u.send_rec(":00000002FE");
      check(28'(wrQ.size()), 28'h1, "bad record programmed");
      check(wrQ[0], {20'h10010, 8'hcc}, "extended write");
      host_u.send_rec(":00000001FF");
      wait_rx(b);
      check(28'(b), 28'(`SHB_CH_ZERO), "no failure char");
      repeat (100) @(posedge ref_clk);
      #1;
      check(28'(loadStatusLedPin), 28'h0, "LED on after error");
      $display("test load_err done");
   endtask : t_load_err

   // Main sequence
   initial begin
      t_app_boot();
      t_load_good();
      t_load_err();
      summarize();
   end

   // Watchdog sized for about 187 characters at the bench bit time
   initial begin
      repeat (60000) @(posedge ref_clk);
      fails++;
      summarize();
   end
endmodule : shb_loader_tb
